// ### src/bpmu_power_unit.v
// Power management unit of a bus target: powerdown filter and wakeup logic.
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/10ps
`include "bpmu_defs.vh"

module bpmu_power_unit #(
   parameter FILT_UNIT_CYC = `BPMU_FILT_UNIT_NS / `BPMU_CLK_NS,
   parameter NUM_SEL = 16
) (
   // Clock and reset.
   input wire mclk,
   input wire sys_rst,
   // Register port.
   input wire [3:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata,
   // UART status, same clock domain.
   input wire uart_irq_pending,
   input wire uart_tx_idle,
   input wire uart_rx_idle,
   // External pins, asynchronous.
   input wire [1:0] aux_io_pin,
   input wire ring_indicator,
   input wire [2:0] modem_lines,
   input wire serial_in_line,
   // Power state effects.
   output wire uart_clk_en,
   output wire irq_block,
   output wire bar_access_en,
   output wire cfg_access_en,
   // Powerdown interrupt and shared wakeup pin.
   output wire pd_irq,
   output wire pme_out
);

   // ****************************************************************
   // Input synchronisers
   // ****************************************************************
   reg [6:0] sync1_reg;
   reg [6:0] sync2_reg;
   // The previous-sample stage feeds the change detectors.
   reg [6:0] prev_reg;
   wire [6:0] pins_raw;
   assign pins_raw = {serial_in_line, modem_lines, ring_indicator,
                      aux_io_pin};

   always @(posedge mclk) begin
      if (sys_rst) begin
         sync1_reg <= 7'h00;
         sync2_reg <= 7'h00;
         prev_reg <= 7'h00;
      end else begin
         sync1_reg <= pins_raw;
         sync2_reg <= sync1_reg;
         prev_reg <= sync2_reg;
      end
   end

   wire [1:0] aux_s;
   wire ri_s;
   wire ri_p;
   assign aux_s = sync2_reg[1:0];
   assign ri_s = sync2_reg[2];
   assign ri_p = prev_reg[2];

   // ****************************************************************
   // Detector arming
   // ****************************************************************
   // The synchronisers clear to zero, which is not the idle level of
   // every pin. Until real samples reach the previous-sample stage, a
   // compare against them would report a false change, so every change
   // and level detector except the ring trailing-edge one stays disarmed for three clocks after reset.
   reg [2:0] arm_reg;
   wire pins_armed;

   always @(posedge mclk) begin
      if (sys_rst) begin
         arm_reg <= 3'h0;
      end else begin
         arm_reg <= {arm_reg[1:0], 1'b1};
      end
   end

   assign pins_armed = arm_reg[2];

   // ****************************************************************
   // Registers
   // ****************************************************************
   reg [31:0] local_control_reg;
   reg [31:0] multipurpose_io_config;
   reg pd_sts_reg;
   reg pd_ien_reg;
   reg uart_wen_reg;
   reg uart_pden_reg;
   reg pme_en_reg;
   reg pme_sts_reg;
   reg [1:0] pstate_reg;
   reg [3:0] dsel_reg;
   reg [4:0] wake_mask_reg;
   reg [7:0] data_mem [0:NUM_SEL-1];
   reg [1:0] scale_mem [0:NUM_SEL-1];
   reg d2_clk_wake_reg;

   function is_addr;
      input [3:0] a;
      input [3:0] ofs;
      begin
         is_addr = (a == ofs);
      end
   endfunction

   wire low_power;
   assign low_power = (pstate_reg == `BPMU_PS_D2) ||
                      (pstate_reg == `BPMU_PS_D3);
   wire in_d2;
   assign in_d2 = (pstate_reg == `BPMU_PS_D2);

   // Aux polarity bit set means the pin interrupts when high.
   wire [1:0] aux_pol;
   assign aux_pol = {multipurpose_io_config[3], multipurpose_io_config[1]};
   wire [1:0] aux_irq_lvl;
   assign aux_irq_lvl = ~(aux_s ^ aux_pol);

   // ****************************************************************
   // Powerdown filter
   // ****************************************************************
   wire uart_pd_en_ok;
   assign uart_pd_en_ok = uart_pden_reg;
   wire uart_pd_req;
   assign uart_pd_req = uart_pd_en_ok & ~uart_irq_pending & uart_tx_idle &
                        uart_rx_idle;
   wire pd_req;
   assign pd_req = uart_pd_req |
                   (pins_armed & (|(~aux_irq_lvl)));
   wire [2:0] filt_sel;
   assign filt_sel = local_control_reg[`BPMU_LCC_FILT_HI:`BPMU_LCC_FILT_LO];

   // The count starts on the clock after the first one that sees the
   // synchronised request. A request that stays valid in ST_DONE keeps the
   // status bit set, because the set wins over the read clear.
   localparam ST_IDLE = 3'b001;
   localparam ST_WAIT = 3'b010;
   localparam ST_DONE = 3'b100;
   reg [2:0] filt_state_reg;
   reg [23:0] filt_cnt_reg;
   reg [23:0] filt_target;
   reg pd_valid;

   always @* begin
      // Zero select disables the filter; each step doubles the time.
      filt_target = FILT_UNIT_CYC[23:0] << filt_sel;
   end

   always @(posedge mclk) begin
      if (sys_rst) begin
         filt_state_reg <= ST_IDLE;
         filt_cnt_reg <= 24'h000000;
      end else begin
         case (filt_state_reg)
            ST_IDLE: begin
               filt_cnt_reg <= 24'h000000;
               if (pd_req && filt_sel != 3'h0) begin
                  filt_state_reg <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               // A dropped request or a disabled filter abandons the count.
               if (!pd_req || filt_sel == 3'h0) begin
                  filt_state_reg <= ST_IDLE;
               end else if (filt_cnt_reg >= filt_target - 24'h000001) begin
                  filt_state_reg <= ST_DONE;
               end else begin
                  filt_cnt_reg <= filt_cnt_reg + 24'h000001;
               end
            end
            ST_DONE: begin
               if (!pd_req) begin
                  filt_state_reg <= ST_IDLE;
               end
            end
            default: begin
               filt_state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   always @* begin
      pd_valid = (filt_state_reg == ST_DONE) && pd_req;
   end

   // ****************************************************************
   // Wakeup sources
   // ****************************************************************
   // Mask bits: 0 ring, 1..3 modem lines, 4 serial input; zero enables.
   wire [4:0] line_chg;
   assign line_chg = (sync2_reg[6:2] ^ prev_reg[6:2]) & ~wake_mask_reg &
                     {5{pins_armed}};
   wire ri_trail;
   assign ri_trail = ri_p & ~ri_s & ~wake_mask_reg[0];
   // In D0 the channel runs, so line activity raises no wakeup there.
   wire uart_wake;
   assign uart_wake = (pstate_reg == `BPMU_PS_D3) ? ri_trail :
                      (pstate_reg == `BPMU_PS_D2) ? (|line_chg) : 1'b0;
   // Aux pins at their interrupt level wake in every power state.
   wire aux_wake;
   assign aux_wake = pins_armed & (|aux_irq_lvl);
   // Wakeups skip the filter on purpose: a resume must not wait out a
   // filter time that was tuned for quiet periods.
   wire wake_evt;
   assign wake_evt = pme_en_reg & ((uart_wake & uart_wen_reg) |
                     aux_wake);

   // ****************************************************************
   // Register writes and sticky flags
   // ****************************************************************
   wire wr_lcc;
   wire wr_mic;
   wire wr_gis;
   wire wr_pm;
   wire wr_msk;
   wire wr_ee;
   wire rd_gis;
   assign wr_lcc = reg_wr & is_addr(reg_addr, `BPMU_OFS_LOCAL_CTRL);
   assign wr_mic = reg_wr & is_addr(reg_addr, `BPMU_OFS_MIO_CFG);
   assign wr_gis = reg_wr & is_addr(reg_addr, `BPMU_OFS_GIS);
   assign wr_pm = reg_wr & is_addr(reg_addr, `BPMU_OFS_PMCSR);
   assign wr_msk = reg_wr & is_addr(reg_addr, `BPMU_OFS_WAKE_MASK);
   assign wr_ee = reg_wr & is_addr(reg_addr, `BPMU_OFS_EE_LOAD);
   assign rd_gis = reg_rd & is_addr(reg_addr, `BPMU_OFS_GIS);

   wire [1:0] new_ps;
   assign new_ps = reg_wdata[1:0];

   integer i;
   always @(posedge mclk) begin
      if (sys_rst) begin
         local_control_reg <= `BPMU_RST_LCC;
         multipurpose_io_config <= `BPMU_RST_MIC;
         pd_sts_reg <= 1'b0;
         pd_ien_reg <= 1'b0;
         uart_wen_reg <= 1'b0;
         uart_pden_reg <= 1'b0;
         pme_en_reg <= 1'b0;
         pme_sts_reg <= 1'b0;
         pstate_reg <= `BPMU_PS_D0;
         dsel_reg <= 4'h0;
         wake_mask_reg <= `BPMU_RST_WMASK;
         d2_clk_wake_reg <= 1'b0;
         for (i = 0; i < NUM_SEL; i = i + 1) begin
            data_mem[i] <= `BPMU_RST_DATA;
            scale_mem[i] <= `BPMU_RST_SCALE;
         end
      end else begin
         if (wr_lcc) begin
            local_control_reg <= reg_wdata;
         end
         if (wr_mic) begin
            multipurpose_io_config <= reg_wdata;
         end
         if (wr_gis) begin
            pd_ien_reg <= reg_wdata[`BPMU_GIS_PD_IEN];
            uart_wen_reg <= reg_wdata[`BPMU_GIS_UART_WEN];
            uart_pden_reg <= reg_wdata[`BPMU_GIS_UART_PDEN];
         end
         // Set wins over the read clear so no request is lost.
         if (pd_valid) begin
            pd_sts_reg <= 1'b1;
         end else if (rd_gis) begin
            pd_sts_reg <= 1'b0;
         end
         if (wr_pm) begin
            pme_en_reg <= reg_wdata[`BPMU_PMCSR_PME_EN];
            dsel_reg <= reg_wdata[`BPMU_PMCSR_DSEL_HI:`BPMU_PMCSR_DSEL_LO];
            // An unsupported state code leaves the state as it was.
            // Only this write moves the power state; no event does.
            if (new_ps == `BPMU_PS_D0 || new_ps == `BPMU_PS_D2 ||
                new_ps == `BPMU_PS_D3) begin
               pstate_reg <= new_ps;
            end
         end
         if (wake_evt) begin
            pme_sts_reg <= 1'b1;
         end else if (wr_pm && reg_wdata[`BPMU_PMCSR_PME_STS]) begin
            pme_sts_reg <= 1'b0;
         end
         if (wr_msk) begin
            wake_mask_reg <= reg_wdata[4:0];
         end
         // Each load access fills one select's data and scale.
         if (wr_ee) begin
            data_mem[reg_wdata[11:8]] <= reg_wdata[7:0];
            scale_mem[reg_wdata[11:8]] <= reg_wdata[13:12];
         end
         // Serial input activity in D2 turns the channel clock back on.
         // Any state but D2 drops it, so a move from D2 straight to D3
         // still leaves the clock stopped there.
         if (pstate_reg == `BPMU_PS_D2 && line_chg[4] && pme_en_reg) begin
            d2_clk_wake_reg <= 1'b1;
         end else if (!in_d2) begin
            d2_clk_wake_reg <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Read data
   // ****************************************************************
   always @(posedge mclk) begin
      if (sys_rst) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_rd) begin
         case (reg_addr)
            `BPMU_OFS_LOCAL_CTRL: reg_rdata <= local_control_reg;
            `BPMU_OFS_MIO_CFG: reg_rdata <= multipurpose_io_config;
            `BPMU_OFS_GIS: begin
               reg_rdata <= {6'h00, uart_pden_reg, uart_wen_reg, 2'h0,
                             pd_ien_reg, pd_sts_reg, 20'h00000};
            end
            `BPMU_OFS_PMCSR: begin
               // Data 31:24, status 15, scale 14:13, select 12:9, enable 8.
               reg_rdata <= {data_mem[dsel_reg], 8'h00, pme_sts_reg,
                             scale_mem[dsel_reg], dsel_reg, pme_en_reg,
                             6'h00, pstate_reg};
            end
            `BPMU_OFS_WAKE_MASK: reg_rdata <= {27'h0000000, wake_mask_reg};
            default: reg_rdata <= 32'h00000000;
         endcase
      end else begin
         // Idle cycles return zero, so stale data never lingers on the bus.
         reg_rdata <= 32'h00000000;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   // The serial wake only counts while the block is still in D2.
   assign uart_clk_en = ~low_power | (d2_clk_wake_reg & in_d2);
   assign irq_block = low_power;
   assign bar_access_en = ~low_power;
   assign cfg_access_en = 1'b1;
   // The low power block covers the powerdown interrupt as well.
   assign pd_irq = pd_sts_reg & pd_ien_reg & ~low_power;
   // Only the live enable and the sticky status drive the pin, so
   // a reset or power loss leaves it deasserted.
   assign pme_out = pme_en_reg & pme_sts_reg;

endmodule // bpmu_power_unit

// ### shared/bpmu_defs.vh
// Constants of the bus power management unit: offsets, fields, resets.
`ifndef BPMU_DEFS_VH
`define BPMU_DEFS_VH

// Register word offsets on the plain register port.
`define BPMU_OFS_LOCAL_CTRL 4'h0
`define BPMU_OFS_MIO_CFG 4'h1
`define BPMU_OFS_GIS 4'h2
`define BPMU_OFS_PMCSR 4'h3
`define BPMU_OFS_WAKE_MASK 4'h4
`define BPMU_OFS_PWR_DATA 4'h5
`define BPMU_OFS_EE_LOAD 4'h6

// Field positions.
`define BPMU_LCC_FILT_LO 5
`define BPMU_LCC_FILT_HI 7
`define BPMU_GIS_PD_STS 20
`define BPMU_GIS_PD_IEN 21
`define BPMU_GIS_UART_WEN 24
`define BPMU_GIS_UART_PDEN 25
`define BPMU_PMCSR_PME_EN 8
`define BPMU_PMCSR_PME_STS 15
`define BPMU_PMCSR_DSEL_LO 9
`define BPMU_PMCSR_DSEL_HI 12
`define BPMU_PMCSR_SCALE_LO 13
`define BPMU_PMCSR_SCALE_HI 14
`define BPMU_PMCSR_DATA_LO 24

// Power state codes of the PMCSR state field.
`define BPMU_PS_D0 2'h0
`define BPMU_PS_D2 2'h2
`define BPMU_PS_D3 2'h3

// Reset values.
`define BPMU_RST_LCC 32'h00000000
`define BPMU_RST_MIC 32'h00000000
`define BPMU_RST_WMASK 5'h00
`define BPMU_RST_DATA 8'h00
`define BPMU_RST_SCALE 2'h0

// Filter time unit and clock period; the filter counter ticks once per clock, 100 ticks per unit.
`define BPMU_FILT_UNIT_NS 1000
`define BPMU_CLK_NS 10

`endif

// ### tb/bpmu_props.sv
// Port checker of the bus power management unit.
`timescale 1ns/10ps
module bpmu_props (
   // Clock and reset.
   input wire mclk,
   input wire sys_rst,
   // Register port.
   input wire [3:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [31:0] reg_rdata,
   // Power state effects and event outputs.
   input wire uart_clk_en,
   input wire irq_block,
   input wire bar_access_en,
   input wire cfg_access_en,
   input wire pd_irq,
   input wire pme_out
);
   reg [1:0] st_reg;
   reg pme_en_reg;
   reg ien_reg;
   wire pm_wr = reg_wr && reg_addr == 4'h3;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);
   // ****************
   // Shadow of the software-written controls.
   // ****************
   always @(posedge mclk) begin
      if (sys_rst) begin
         st_reg <= 2'h0;
         pme_en_reg <= 1'b0;
         ien_reg <= 1'b0;
      end else begin
         if (pm_wr && reg_wdata[1:0] != 2'h1)
            st_reg <= reg_wdata[1:0];
         if (pm_wr)
            pme_en_reg <= reg_wdata[8];
         if (reg_wr && reg_addr == 4'h2)
            ien_reg <= reg_wdata[21];
      end
   end
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside its cycle");
   pme_gate_a: assert property (pme_out |-> pme_en_reg)
      else $error("wakeup output without enable");
   blk_state_a: assert property (irq_block == st_reg[1])
      else $error("interrupt block does not follow state");
   bar_state_a: assert property (bar_access_en != st_reg[1])
      else $error("bar access does not follow state");
   cfg_on_a: assert property (cfg_access_en)
      else $error("config access lost");
   pd_gate_a: assert property (pd_irq |-> ien_reg && st_reg == 2'h0)
      else $error("powerdown interrupt not gated");
   pme_hold_a: assert property ($fell(pme_out) |->
      $past(pm_wr && (reg_wdata[15] || !reg_wdata[8])))
      else $error("wakeup output dropped by itself");
   pd_hold_a: assert property ($fell(pd_irq) |-> $past(reg_rd || reg_wr))
      else $error("powerdown status dropped by itself");
   uclk_low_a: assert property (st_reg == 2'h3 |-> !uart_clk_en)
      else $error("uart clock runs in D3");
   uclk_run_a: assert property (st_reg == 2'h0 |-> uart_clk_en)
      else $error("uart clock stopped in D0");
   st_keep_a: assert property (pm_wr && reg_wdata[1:0] == 2'h1 |=>
      $stable(irq_block) && $stable(bar_access_en))
      else $error("unsupported state accepted");
   cover property ($rose(pd_irq));
   cover property ($rose(pme_out));
   cover property (irq_block && pme_out);
   cover property (irq_block && uart_clk_en);
endmodule // bpmu_props

// ### tb/bpmu_pin_model.sv
// Model of the pins and serial channel facing the power unit.
`timescale 1ns/10ps
module bpmu_pin_model (
   // Clock.
   input wire mclk,
   // Bench requests.
   input wire [1:0] aux_lvl,
   input wire uart_quiet,
   input wire ring_go,
   input wire serial_lvl,
   // Pins toward the unit.
   output reg [1:0] aux_io_pin = 2'h0,
   output wire ring_indicator,
   output wire [2:0] modem_lines,
   output wire serial_in_line,
   output wire uart_irq_pending,
   output wire uart_tx_idle,
   output wire uart_rx_idle
);
   reg [2:0] ring_cnt = 3'h0;
   // A quiet channel has nothing pending and both directions idle.
   assign uart_irq_pending = ~uart_quiet;
   assign uart_tx_idle = uart_quiet;
   assign uart_rx_idle = uart_quiet;
   // Modem lines rest at the idle mark level; the bench moves the
   // serial input to stand for line activity.
   assign modem_lines = 3'h7;
   assign serial_in_line = serial_lvl;
   // A ring lasts four cycles, so its trailing edge is seen apart.
   assign ring_indicator = ring_cnt != 3'h0;
   always @(posedge mclk) begin
      aux_io_pin <= aux_lvl;
      if (ring_go)
         ring_cnt <= 3'h4;
      else if (ring_cnt != 3'h0)
         ring_cnt <= ring_cnt - 3'h1;
   end
endmodule // bpmu_pin_model

// ### tb/tb_bpmu_power_unit.sv
// Self-checking bench of the bus power management unit.
`timescale 1ns/10ps
module tb_bpmu_power_unit;
   reg mclk = 1'b0;
   reg sys_rst = 1'b1;
   reg [3:0] reg_addr = 4'h0;
   reg [31:0] reg_wdata = 32'h0;
   reg reg_wr = 1'b0;
   reg reg_rd = 1'b0;
   reg [1:0] aux_lvl = 2'h0;
   reg uart_quiet = 1'b0;
   reg ring_go = 1'b0;
   reg serial_lvl = 1'b1;
   wire [31:0] reg_rdata;
   wire [1:0] aux_io_pin;
   wire [2:0] modem_lines;
   wire ring_indicator, serial_in_line, uart_irq_pending;
   wire uart_tx_idle, uart_rx_idle, uart_clk_en, irq_block;
   wire bar_access_en, cfg_access_en, pd_irq, pme_out;
   wire [31:0] fx = {28'h0, irq_block, bar_access_en, cfg_access_en,
      uart_clk_en};
   wire [31:0] pd32 = {31'h0, pd_irq};
   wire [31:0] pme32 = {31'h0, pme_out};
   integer miscompares = 0;
   integer checks = 0;
   integer cycles = 0;
   always #5 mclk = ~mclk;
   bpmu_power_unit #(.FILT_UNIT_CYC(2)) i_dut (
      .mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .uart_irq_pending(uart_irq_pending),
      .uart_tx_idle(uart_tx_idle), .uart_rx_idle(uart_rx_idle),
      .aux_io_pin(aux_io_pin), .ring_indicator(ring_indicator),
      .modem_lines(modem_lines), .serial_in_line(serial_in_line),
      .uart_clk_en(uart_clk_en), .irq_block(irq_block),
      .bar_access_en(bar_access_en), .cfg_access_en(cfg_access_en),
      .pd_irq(pd_irq), .pme_out(pme_out));
   bpmu_pin_model i_pins (
      .mclk(mclk), .aux_lvl(aux_lvl), .uart_quiet(uart_quiet),
      .ring_go(ring_go), .serial_lvl(serial_lvl), .aux_io_pin(aux_io_pin),
      .ring_indicator(ring_indicator), .modem_lines(modem_lines),
      .serial_in_line(serial_in_line),
      .uart_irq_pending(uart_irq_pending),
      .uart_tx_idle(uart_tx_idle), .uart_rx_idle(uart_rx_idle));
   // ****************
   // Bus tasks and checks; every task returns 1 ns after an edge.
   // ****************
   task cmp(input [31:0] g, input [31:0] e);
      begin
         checks = checks + 1;
         if (g !== e) begin
            miscompares = miscompares + 1;
            $display("Error at %0t: got %h expected %h", $time, g, e);
         end
      end
   endtask
   task cyc(input integer n);
      begin
         repeat (n) @(posedge mclk);
         #1;
      end
   endtask
   task wr(input [3:0] a, input [31:0] d);
      begin
         reg_addr <= a;
         reg_wdata <= d;
         reg_wr <= 1'b1;
         @(posedge mclk);
         reg_wr <= 1'b0;
         #1;
      end
   endtask
   task rd(input [3:0] a, input [31:0] e);
      begin
         reg_addr <= a;
         reg_rd <= 1'b1;
         @(posedge mclk);
         reg_rd <= 1'b0;
         #1;
         cmp(reg_rdata, e);
      end
   endtask
   task ring;
      begin
         ring_go <= 1'b1;
         cyc(1);
         ring_go <= 1'b0;
      end
   endtask
   task finish_test;
      begin
         $display("Checks %0d, miscompares %0d", checks, miscompares);
         if (miscompares == 0 && checks > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   always @(posedge mclk) begin
      cycles = cycles + 1;
      if (cycles == 3000) begin
         miscompares = miscompares + 1;
         finish_test;
      end
   end
   initial begin
      cyc(3);
      sys_rst <= 1'b0;
      rd(4'h2, 32'h0);
      rd(4'h3, 32'h0);
      rd(4'h7, 32'h0);
      cmp(fx, 32'h7);
      wr(4'h0, 32'h40);
      wr(4'h2, 32'h0020_0000);
      aux_lvl <= 2'h1;
      cyc(5);
      aux_lvl <= 2'h0;
      cyc(20);
      cmp(pd32, 32'h0);
      aux_lvl <= 2'h1;
      cyc(6);
      cmp(pd32, 32'h0);
      cyc(15);
      cmp(pd32, 32'h1);
      aux_lvl <= 2'h0;
      cyc(4);
      cmp(pd32, 32'h1);
      rd(4'h2, 32'h0030_0000);
      rd(4'h2, 32'h0020_0000);
      cmp(pd32, 32'h0);
      wr(4'h2, 32'h0220_0000);
      uart_quiet <= 1'b1;
      cyc(20);
      cmp(pd32, 32'h1);
      uart_quiet <= 1'b0;
      cyc(1);
      rd(4'h2, 32'h0230_0000);
      cmp(pme32, 32'h0);
      wr(4'h3, 32'h100);
      cyc(6);
      cmp(pme32, 32'h1);
      rd(4'h3, 32'h8100);
      wr(4'h1, 32'hA);
      cyc(6);
      cmp(pme32, 32'h1);
      wr(4'h3, 32'h8100);
      cmp(pme32, 32'h0);
      wr(4'h3, 32'h103);
      cmp(fx, 32'hA);
      cmp(pd32, 32'h0);
      wr(4'h3, 32'h101);
      rd(4'h3, 32'h103);
      ring;
      cyc(12);
      cmp(pme32, 32'h0);
      wr(4'h2, 32'h0120_0000);
      ring;
      cyc(3);
      cmp(pme32, 32'h0);
      cyc(10);
      cmp(pme32, 32'h1);
      rd(4'h3, 32'h8103);
      wr(4'h3, 32'h8100);
      cmp(fx, 32'h7);
      wr(4'h6, 32'h25AB);
      wr(4'h3, 32'hA00);
      rd(4'h3, 32'hAB00_4A00);
      wr(4'h3, 32'hC00);
      rd(4'h3, 32'hC00);
      wr(4'h3, 32'h8102);
      cmp(fx, 32'hA);
      wr(4'h4, 32'h10);
      serial_lvl <= 1'b0;
      cyc(4);
      cmp(pme32, 32'h0);
      cmp(fx, 32'hA);
      wr(4'h4, 32'h0);
      serial_lvl <= 1'b1;
      cyc(4);
      cmp(pme32, 32'h1);
      cmp(fx, 32'hB);
      wr(4'h3, 32'h103);
      cmp(fx, 32'hA);
      wr(4'h3, 32'h8100);
      cmp(pme32, 32'h0);
      cmp(fx, 32'h7);
      finish_test;
   end
endmodule // tb_bpmu_power_unit
bind bpmu_power_unit bpmu_props i_props (
   .mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .uart_clk_en(uart_clk_en),
   .irq_block(irq_block), .bar_access_en(bar_access_en),
   .cfg_access_en(cfg_access_en), .pd_irq(pd_irq), .pme_out(pme_out));
